// ---- cmd_decoder_defs.vh ----
// Constants for the explicit request decoder of the networked position encoder.
// Assumes a transport front end that presents one parsed request at a time.
// Behaviour
// RULE_01: A read request with service 0x0E, class 4, attribute 3 and instance 1 returns the position as four bytes.
// RULE_02: A read request with instance 3 returns eight bytes, position first and then velocity.
// RULE_03: Which data set is returned depends only on the instance of the read request.
// RULE_04: A configuration write is service 0x10 to class 4, attribute 3, instance 103 with exactly twelve bytes.
// RULE_05: A position preset is service 0x10 to class 0x23, attribute 0x13, instance 1 with four bytes in two words.
// RULE_06: Restore factory defaults (service 5, class 0x23) loads defaults into working memory and leaves IP settings alone.
// RULE_07: Defaults reach flash only through a later save command (service 0x16, no data); restore from flash is service 0x15.
// RULE_08: The position reply sends the low 16-bit word first and the high word second.
// RULE_09: The position and velocity reply sends four words: position low, position high, velocity low, velocity high.
// RULE_10: A reported position never exceeds the 30-bit ceiling.
// RULE_11: Once scaling has ever been enabled, velocity is derived from scaled position in the configured velocity units.
// RULE_12: The standard position sensor object, revision 2, is reachable by explicit messaging.
// RULE_13: The host sends every request as a generic message to the device address.
// RULE_14: A reset is service 5 to class 1, instance 1, with no attribute and no data.
// RULE_15: Configuration written by the configure command is held in volatile storage until a save command.
// RULE_16: Any request matching no supported command is answered with an error and changes nothing.
// RULE_17: Position and velocity are captured together as one sample before words are sent.
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH
`define SVC_READ_ASM      8'h0E
`define SVC_SET_SINGLE    8'h10
`define SVC_SAVE_FLASH    8'h16
`define SVC_LOAD_FLASH    8'h15
`define SVC_DEFAULTS      8'h05
`define CLS_ASSEMBLY      8'h04
`define CLS_POS_SENSOR    8'h23
`define CLS_IDENTITY      8'h01
`define ATTR_ASM_DATA     8'h03
`define ATTR_PRESET       8'h13
`define ATTR_NONE         8'h00
`define INST_POS          8'h01
`define INST_POS_VEL      8'h03
`define INST_CONFIG       8'h67
`define INST_NONE         8'h00
`define INST_IDENTITY     8'h01
`define LEN_POS           8'h04
`define LEN_POS_VEL       8'h08
`define LEN_CONFIG        8'h0C
`define LEN_PRESET        8'h04
`define LEN_NONE          8'h00
`define POS_CEILING       32'h3FFFFFFF
`define STS_OK            8'h00
`define STS_ERROR         8'h08
`define CFG_SCALE_BYTE    1
`define CFG_BYTES         12
`endif

// ---- cmd_decoder.v ----
// Explicit request decoder: recognises read assemblies and write commands, returns words.
// Assumes the front end holds a request stable while req_valid is high and
// takes reply words while word_valid is high; sensor object access is forwarded.
`include "cmd_decoder_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module cmd_decoder (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        sys_rst,
	// Parsed request
	input  wire        req_valid,
	output wire        req_ready,
	input  wire [7:0]  req_service,
	input  wire [7:0]  req_class,
	input  wire [7:0]  req_instance,
	input  wire [7:0]  req_attribute,
	input  wire [7:0]  req_length,
	// Request payload bytes, delivered one per cycle after a write is accepted
	input  wire        data_valid,
	input  wire [7:0]  data_byte,
	// Reply
	output reg         resp_valid,
	output reg  [7:0]  resp_status,
	output reg  [7:0]  resp_length,
	output reg         word_valid,
	output reg  [15:0] word_data,
	input  wire        word_ready,
	// Live measurement
	input  wire [31:0] live_position,
	input  wire [31:0] live_velocity,
	// Working configuration and actions toward the encoder core
	output reg  [95:0] config_ram,
	output reg         scaling_ever,
	output reg         preset_load,
	output reg  [31:0] preset_value,
	output reg         save_flash,
	output reg         load_flash,
	output reg         load_defaults,
	output reg         device_reset,
	// Sensor object requests, forwarded whole
	output reg         sensor_req,
	input  wire        sensor_done
);
	localparam ST_IDLE  = 3'd0;
	localparam ST_DATA  = 3'd1;
	localparam ST_WORDS = 3'd2;
	localparam ST_RESP  = 3'd3;
	localparam ST_SENS  = 3'd4;
	localparam C_CONFIG = 2'd1;
	localparam C_PRESET = 2'd2;

	reg [2:0]  state_reg;
	reg [1:0]  cmd_reg;
	reg [3:0]  byte_cnt_reg;
	reg [1:0]  word_idx_reg;
	reg [1:0]  word_last_reg;
	reg [63:0] sample_reg;
	reg [95:0] shadow_reg;

	function match;
		input [39:0] h;
		input [7:0]  es, ec, ei, ea, el;
		begin
			match = (h == {es, ec, ei, ea, el});
		end
	endfunction

	// The whole header is compared at once, so a size mismatch fails like any other field.
	wire [39:0] req_hdr = {req_service, req_class, req_instance, req_attribute, req_length};

	wire is_rd_pos = match(req_hdr, `SVC_READ_ASM, `CLS_ASSEMBLY, `INST_POS, `ATTR_ASM_DATA,
		`LEN_NONE); // RULE_01 RULE_03
	wire is_rd_pv  = match(req_hdr, `SVC_READ_ASM, `CLS_ASSEMBLY, `INST_POS_VEL,
		`ATTR_ASM_DATA, `LEN_NONE); // RULE_02 RULE_03
	wire is_cfg    = match(req_hdr, `SVC_SET_SINGLE, `CLS_ASSEMBLY, `INST_CONFIG,
		`ATTR_ASM_DATA, `LEN_CONFIG); // RULE_04
	wire is_preset = match(req_hdr, `SVC_SET_SINGLE, `CLS_POS_SENSOR, `INST_POS,
		`ATTR_PRESET, `LEN_PRESET); // RULE_05
	wire is_save   = match(req_hdr, `SVC_SAVE_FLASH, `CLS_POS_SENSOR, `INST_NONE,
		`ATTR_NONE, `LEN_NONE); // RULE_07
	wire is_load   = match(req_hdr, `SVC_LOAD_FLASH, `CLS_POS_SENSOR, `INST_NONE,
		`ATTR_NONE, `LEN_NONE); // RULE_07
	wire is_dflt   = match(req_hdr, `SVC_DEFAULTS, `CLS_POS_SENSOR, `INST_NONE,
		`ATTR_NONE, `LEN_NONE); // RULE_06
	wire is_reset  = match(req_hdr, `SVC_DEFAULTS, `CLS_IDENTITY, `INST_IDENTITY,
		`ATTR_NONE, `LEN_NONE); // RULE_14
	// A malformed preset or custom command aimed at the sensor class is refused here rather
	// than forwarded, so a wrong size never reaches the sensor object with stray bytes.
	wire hits_preset = (req_service == `SVC_SET_SINGLE) && (req_class == `CLS_POS_SENSOR) &&
		(req_instance == `INST_POS) && (req_attribute == `ATTR_PRESET); // RULE_16
	wire is_custom   = (req_service == `SVC_SAVE_FLASH) || (req_service == `SVC_LOAD_FLASH) ||
		(req_service == `SVC_DEFAULTS); // RULE_16
	// Any other service aimed at the sensor class goes to the sensor object.
	wire is_sensor = (req_class == `CLS_POS_SENSOR) && !hits_preset && !is_custom; // RULE_12

	// Clamping here keeps every reported position at or under the ceiling whatever the core hands over; velocity is not clamped.
	wire [31:0] pos_clamped = (live_position > `POS_CEILING) ? `POS_CEILING
		: live_position; // RULE_10

	assign req_ready = (state_reg == ST_IDLE);

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg     <= ST_IDLE;
			cmd_reg       <= 2'd0;
			byte_cnt_reg  <= 4'd0;
			word_idx_reg  <= 2'd0;
			word_last_reg <= 2'd0;
			sample_reg    <= 64'h0000000000000000;
			shadow_reg    <= 96'h0;
			config_ram    <= 96'h0;
			scaling_ever  <= 1'b0;
			preset_load   <= 1'b0;
			preset_value  <= 32'h00000000;
			save_flash    <= 1'b0;
			load_flash    <= 1'b0;
			load_defaults <= 1'b0;
			device_reset  <= 1'b0;
			sensor_req    <= 1'b0;
			resp_valid    <= 1'b0;
			resp_status   <= 8'h00;
			resp_length   <= 8'h00;
			word_valid    <= 1'b0;
			word_data     <= 16'h0000;
		end else begin
			preset_load   <= 1'b0;
			save_flash    <= 1'b0;
			load_flash    <= 1'b0;
			load_defaults <= 1'b0;
			device_reset  <= 1'b0;
			resp_valid    <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (req_valid) begin
					resp_status <= `STS_OK;
					resp_length <= 8'h00;
					if (is_rd_pos || is_rd_pv) begin
						// One capture for both values keeps every word of a reply coherent.
						sample_reg    <= {live_velocity, pos_clamped}; // RULE_17 RULE_11
						word_idx_reg  <= 2'd0;
						word_last_reg <= is_rd_pv ? 2'd3 : 2'd1; // RULE_03
						resp_length   <= is_rd_pv ? `LEN_POS_VEL : `LEN_POS;
						word_valid    <= 1'b1;
						word_data     <= pos_clamped[15:0]; // RULE_08
						state_reg     <= ST_WORDS;
					end else if (is_cfg || is_preset) begin
						cmd_reg      <= is_cfg ? C_CONFIG : C_PRESET;
						byte_cnt_reg <= 4'd0;
						state_reg    <= ST_DATA;
					end else if (is_save) begin
						save_flash <= 1'b1; // RULE_07 RULE_15
						resp_valid <= 1'b1;
					end else if (is_load) begin
						load_flash <= 1'b1; // RULE_07
						resp_valid <= 1'b1;
					end else if (is_dflt) begin
						// Only the working copy changes; addressing lives elsewhere.
						load_defaults <= 1'b1; // RULE_06
						config_ram    <= 96'h0;
						resp_valid    <= 1'b1;
					end else if (is_reset) begin
						device_reset <= 1'b1; // RULE_14
						resp_valid   <= 1'b1;
					end else if (is_sensor) begin
						sensor_req <= 1'b1; // RULE_12
						state_reg  <= ST_SENS;
					end else begin
						resp_status <= `STS_ERROR; // RULE_16
						resp_valid  <= 1'b1;
					end
				end
			end
			ST_DATA: begin
				// Bytes arrive low first and shift in from the top, so byte 0 ends at the bottom.
				if (data_valid) begin
					shadow_reg   <= {data_byte, shadow_reg[95:8]};
					byte_cnt_reg <= byte_cnt_reg + 4'd1;
					if ((cmd_reg == C_PRESET) && (byte_cnt_reg == 4'd3)) begin
						preset_value <= {data_byte, shadow_reg[95:72]}; // RULE_05
						preset_load  <= 1'b1;
						resp_valid   <= 1'b1;
						state_reg    <= ST_IDLE;
					end else if (byte_cnt_reg == 4'd11) begin
						// Held only in working storage until a save request.
						config_ram <= {data_byte, shadow_reg[95:8]}; // RULE_04 RULE_15
						if (shadow_reg[8*(`CFG_SCALE_BYTE+1)+7 -: 8] != 8'h00)
							scaling_ever <= 1'b1; // RULE_11
						resp_valid <= 1'b1;
						state_reg  <= ST_IDLE;
					end
				end
			end
			ST_WORDS: begin
				// A word moves on only when the host takes it, so a slow host stretches the reply.
				if (word_ready) begin
					if (word_idx_reg == word_last_reg) begin
						word_valid <= 1'b0;
						resp_valid <= 1'b1;
						state_reg  <= ST_IDLE;
					end else begin
						word_idx_reg <= word_idx_reg + 2'd1;
						case (word_idx_reg)
						2'd0: word_data <= sample_reg[31:16]; // RULE_08
						2'd1: word_data <= sample_reg[47:32]; // RULE_09
						default: word_data <= sample_reg[63:48]; // RULE_09
						endcase
					end
				end
			end
			ST_SENS: begin
				// The sensor object answers in its own time; the decoder stays busy until then.
				if (sensor_done) begin
					sensor_req <= 1'b0;
					resp_valid <= 1'b1;
					state_reg  <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- host_model.sv ----
// Host side model: takes reply words and answers forwarded sensor requests.
// Assumes the decoder's single clock; slow makes the host stall every other cycle.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// Clock and pace
	input wire logic        sys_clk,
	input wire logic        slow,
	// Reply words
	input wire logic        word_valid,
	input wire logic [15:0] word_data,
	output var logic        word_ready,
	// Sensor object handshake
	input wire logic        sensor_req,
	output var logic        sensor_done
);
	logic [15:0] got[$];
	initial {word_ready, sensor_done} = 2'b00;
	always @(posedge sys_clk) begin
		if (word_valid && word_ready)
			got.push_back(word_data);
		word_ready <= slow ? !word_ready : 1'b1;
		sensor_done <= sensor_req && !sensor_done;
	end
endmodule
`default_nettype wire

// ---- cmd_decoder_monitor.sv ----
// Checker for the request decoder's port behaviour.
// Assumes one clock domain with the asynchronous high reset.
`include "cmd_decoder_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module cmd_decoder_monitor (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	// Request
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [7:0]  req_service,
	input wire logic [7:0]  req_class,
	input wire logic [7:0]  req_instance,
	input wire logic [7:0]  req_attribute,
	input wire logic [7:0]  req_length,
	// Reply and actions
	input wire logic        resp_valid,
	input wire logic [7:0]  resp_status,
	input wire logic        word_valid,
	input wire logic [15:0] word_data,
	input wire logic        word_ready,
	input wire logic        preset_load,
	input wire logic        save_flash,
	input wire logic        load_flash,
	input wire logic        load_defaults,
	input wire logic        device_reset,
	input wire logic        sensor_req,
	input wire logic        sensor_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	hold_word_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
		else $error("reply word changed before it was taken");
	read_start_a: assert property (req_valid && req_ready && req_service == `SVC_READ_ASM &&
		req_class == `CLS_ASSEMBLY && req_attribute == `ATTR_ASM_DATA && req_length == `LEN_NONE &&
		(req_instance == `INST_POS || req_instance == `INST_POS_VEL) |=> word_valid) else $error("read gave no word");
	no_effect_a: assert property (resp_valid && resp_status == `STS_ERROR |->
		!(preset_load || save_flash || load_flash || load_defaults || device_reset)) else $error("error had effect");
	resp_pulse_a: assert property (resp_valid |=> !resp_valid) else $error("finish pulse too long");
	busy_refuse_a: assert property (word_valid |-> !req_ready) else $error("ready while replying");
	sensor_hold_a: assert property (sensor_req && !sensor_done |=> sensor_req)
		else $error("sensor request dropped early");
	preset_once_a: assert property (preset_load |=> !preset_load) else $error("preset pulse too long");
	save_once_a: assert property (save_flash |=> !save_flash) else $error("save pulse too long");
	bad_size_a: assert property (req_valid && req_ready && req_service == `SVC_SET_SINGLE &&
		req_class == `CLS_POS_SENSOR && req_instance == `INST_POS && req_attribute == `ATTR_PRESET &&
		req_length != `LEN_PRESET |=> resp_valid && resp_status == `STS_ERROR && !sensor_req)
		else $error("malformed preset not refused");
endmodule
bind cmd_decoder cmd_decoder_monitor mon (.sys_clk, .sys_rst, .req_valid, .req_ready, .req_service,
	.req_class, .req_instance, .req_attribute, .req_length, .resp_valid, .resp_status, .word_valid,
	.word_data, .word_ready, .preset_load, .save_flash, .load_flash, .load_defaults, .device_reset,
	.sensor_req, .sensor_done);
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the request decoder with a host model on the reply side.
// Assumes the decoder's defines header and the host model file are compiled first.
`include "cmd_decoder_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, data_valid = 1'b0, slow = 1'b0;
	logic [7:0]  req_service = 8'h00, req_class = 8'h00, req_instance = 8'h00, req_attribute = 8'h00;
	logic [7:0]  req_length = 8'h00, data_byte = 8'h00, st;
	logic [31:0] live_position = 32'h00000000, live_velocity = 32'h00000000;
	logic [5:0]  pul;
	wire         req_ready, resp_valid, word_valid, word_ready, scaling_ever, preset_load;
	wire         save_flash, load_flash, load_defaults, device_reset, sensor_req, sensor_done;
	wire [7:0]   resp_status, resp_length;
	wire [15:0]  word_data;
	wire [95:0]  config_ram;
	wire [31:0]  preset_value;
	int          err_total = 0, n_compared = 0;
	logic [39:0] hdr_t[7] = '{40'h1623000000, 40'h1523000000, 40'h0523000000, 40'h0501010000,
		40'h0E04020300, 40'h1023011300, 40'h0E23010100};
	logic [13:0] exp_t[7] = '{14'h0002, 14'h0004, 14'h0008, 14'h0010, 14'h0200, 14'h0200, 14'h0020};
	always #4 sys_clk = ~sys_clk;
	cmd_decoder DUT (.sys_clk, .sys_rst, .req_valid, .req_ready, .req_service, .req_class,
		.req_instance, .req_attribute, .req_length, .data_valid, .data_byte, .resp_valid,
		.resp_status, .resp_length, .word_valid, .word_data, .word_ready, .live_position,
		.live_velocity, .config_ram, .scaling_ever, .preset_load, .preset_value, .save_flash,
		.load_flash, .load_defaults, .device_reset, .sensor_req, .sensor_done);
	host_model host (.sys_clk, .slow, .word_valid, .word_data, .word_ready, .sensor_req, .sensor_done);
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	// Every wait is bounded; a hang is scored and ends the run at once.
	task automatic cmd(input logic [39:0] hdr, input logic [95:0] pay);
		int k;
		logic ok;
		@(posedge sys_clk);
		{req_service, req_class, req_instance, req_attribute, req_length} <= hdr;
		req_valid <= 1'b1;
		pul = 6'h00;
		k = 0;
		// Ready is read mid-cycle, where it stands settled for the coming edge.
		do begin
			@(negedge sys_clk);
			ok = req_ready;
			@(posedge sys_clk);
			k++;
		end while (!ok && k < 40);
		req_valid <= 1'b0;
		if (!ok) begin
			check(0, 1, "no accept");
			stop_test;
		end
		for (int j = 0; j < hdr[7:0]; j++) begin
			data_valid <= 1'b1;
			data_byte <= pay[8*j +: 8];
			@(posedge sys_clk);
		end
		data_valid <= 1'b0;
		for (k = 0; k < 40; k++) begin
			#1;
			pul |= {sensor_req, device_reset, load_defaults, load_flash, save_flash, preset_load};
			if (resp_valid)
				break;
			@(posedge sys_clk);
		end
		if (k == 40) begin
			check(0, 1, "no answer");
			stop_test;
		end
		st = resp_status;
	endtask
	task automatic t_read;
		slow <= 1'b1;
		live_position <= 32'h0013717D;
		host.got.delete();
		cmd({`SVC_READ_ASM, `CLS_ASSEMBLY, `INST_POS, `ATTR_ASM_DATA, `LEN_NONE}, 96'h0);
		check(resp_length, `LEN_POS, "position length");
		check({host.got.size(), host.got[1], host.got[0]}, {32'd2, 32'h0013717D}, "position words");
		live_position <= 32'hFFFFFFFF;
		host.got.delete();
		cmd({`SVC_READ_ASM, `CLS_ASSEMBLY, `INST_POS, `ATTR_ASM_DATA, `LEN_NONE}, 96'h0);
		check({host.got[1], host.got[0]}, `POS_CEILING, "position ceiling");
	endtask
	task automatic t_pv;
		live_position <= 32'h0013717D;
		live_velocity <= 32'h00070B9D;
		host.got.delete();
		fork
			cmd({`SVC_READ_ASM, `CLS_ASSEMBLY, `INST_POS_VEL, `ATTR_ASM_DATA, `LEN_NONE}, 96'h0);
			begin repeat (3) @(posedge sys_clk); live_position <= 32'h0; live_velocity <= 32'h0; end
		join
		check(resp_length, `LEN_POS_VEL, "pair length");
		check({host.got[3], host.got[2], host.got[1], host.got[0]}, 64'h00070B9D0013717D, "pair");
	endtask
	task automatic t_write;
		cmd({`SVC_SET_SINGLE, `CLS_ASSEMBLY, `INST_CONFIG, `ATTR_ASM_DATA, `LEN_CONFIG}, 96'h09E340000099CA0100);
		check({st, config_ram}, {`STS_OK, 96'h09E340000099CA0100}, "configuration");
		check(scaling_ever, 1'b1, "scaling flag");
		cmd({`SVC_SET_SINGLE, `CLS_POS_SENSOR, `INST_POS, `ATTR_PRESET, `LEN_PRESET}, 96'h12345678);
		check({pul, preset_value}, {6'h01, 32'h12345678}, "preset");
	endtask
	task automatic t_table;
		for (int i = 0; i < 7; i++) begin
			cmd(hdr_t[i], 96'h0);
			check({st, pul}, exp_t[i], "command outcome");
			if (i == 2)
				check(config_ram, 96'h0, "defaults in working memory");
		end
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_read;
		t_pv;
		t_write;
		t_table;
		stop_test;
	end
endmodule
`default_nettype wire
